// >>> common/aux_bus_map.vh
// Register map, field positions and timing counts for the aux bus control
`ifndef AUX_BUS_MAP_VH
`define AUX_BUS_MAP_VH

`define AUX_BUS_CONTROL_OFFSET  8'h8e
`define AUX_BUS_CONTROL_ADDR    12'h238
`define AUX_STATUS_ADDR         12'h240
`define AUX_STROBE_CMD_ADDR     12'h244
`define AUX_BUS_CONTROL_RESET   8'h0c
`define AUX_WRITABLE_MASK       8'haf
`define FLD_SUPPRESS            0
`define FLD_EXT_SELECT          1
`define FLD_XRAM_LO             2
`define FLD_XRAM_HI             3
`define FLD_STRETCH             5
`define FLD_PULLUP_DISABLE      7
`define LATCH_DIV_NORMAL        4'h6
`define LATCH_DIV_DOUBLE        4'h3
`define STROBE_SHORT            5'h06
`define STROBE_LONG             5'h1e

`endif

// >>> core/aux_bus_control.v
// APB register bank for aux bus control and emulation mode entry
//
// Register access over APB was decided locally.
`include "aux_bus_map.vh"

// How it works
// R1: Latch strobe held low, program strobe high, through reset release.
// R2: Emulation pulls up strobes and ports 1-3, floats port 0 and I2.
// R3: Emulation lasts until the next ordinary reset.
// R4: Suppress clear: latch strobe at clock/6, clock/3 in double speed.
// R5: Suppress set (bit 0): latch strobe only during external accesses.
// R6: While suppressed and idle the latch pin is weakly pulled high.
// R7: Read/write strobes last 6 clocks, or 30 with stretch set.
// R8: Two size bits pick 256, 512, 768 or 1024 bytes of internal RAM.
// R9: Ext select clear keeps data moves inside, set sends them out.
// R10: Pull-up disable clear enables port weak pull-ups, set disables.
// R11: Software never sets reserved bits 6 and 4.
// R12: Control register resets to 0x0c and is written as a whole byte.
// R13: Latch strobe splits address from data on port 0.
// R14: Strobe pins are sampled at reset release for emulation entry.
module aux_bus_control
(
    // Clock and reset
    input  wire        clock,
    input  wire        sys_rst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // Core side
    input  wire        doubleSpeed,
    input  wire        extAccess,
    // Strobe pins
    input  wire        latchStrobeIn,
    input  wire        progStoreStrobeIn,
    output wire        latchStrobeOut,
    output wire        latchStrobeOe,
    output wire        latchStrobePullup,
    output wire        progStorePullup,
    output wire        rwStrobeActive,
    // Memory and port controls
    output wire        extDataSelect,
    output reg  [10:0] xramSize,
    output wire        portWeakPullup,
    output wire        port0Float,
    output wire        portI2Float,
    output wire        oscActive,
    output wire        emulationMode
);

    ////////////////////////////////////////////////////////////////////
    // Registers and decode

    localparam ST_IDLE   = 1'b0;
    localparam ST_STROBE = 1'b1;

    reg  [7:0] auxBusControl_reg;
    reg        emulation_reg;
    reg        rstSeen_reg;
    reg        state_reg;
    reg  [4:0] strobeCount_reg;
    wire       access;
    wire       hitCtrl;
    wire       hitStat;
    wire       hitCmd;
    wire       strobeOut;
    wire       strobeDrive;

    function [10:0] size_decode;
        input [1:0] code;
        begin
            size_decode = {1'b0, code, 8'h00} + 11'h100;
        end
    endfunction

    assign access  = psel && penable;
    assign hitCtrl = (paddr == `AUX_BUS_CONTROL_ADDR);
    assign hitStat = (paddr == `AUX_STATUS_ADDR);
    assign hitCmd  = (paddr == `AUX_STROBE_CMD_ADDR);
    assign pready  = 1'b1;
    assign pslverr = access && !(hitCtrl || hitStat || hitCmd);

    ////////////////////////////////////////////////////////////////////
    // Control register

    always @(posedge clock)
    begin
        if (sys_rst)
            auxBusControl_reg <= `AUX_BUS_CONTROL_RESET;      // [R12]
        else if (access && pwrite && hitCtrl)
            // Whole byte only, reserved bits kept zero
            auxBusControl_reg <= pwdata[7:0] & `AUX_WRITABLE_MASK; // [R12]
    end

    always @(posedge clock)
    begin
        if (sys_rst)
            prdata <= 32'h00000000;
        else if (psel && !penable)
        begin
            if (hitCtrl)
                prdata <= {24'h000000, auxBusControl_reg};
            else if (hitStat)
                prdata <= {30'h00000000, state_reg, emulation_reg};
            else
                prdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Emulation mode entry

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            rstSeen_reg     <= 1'b1;
            emulation_reg   <= 1'b0;                          // [R3]
        end
        else
        begin
            rstSeen_reg     <= 1'b0;
            // First edge after release samples the pins
            if (rstSeen_reg && !latchStrobeIn && progStoreStrobeIn)
                emulation_reg <= 1'b1;                        // [R14] [R1]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read/write strobe length

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_reg       <= ST_IDLE;
            strobeCount_reg <= 5'h00;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (access && pwrite && hitCmd)
                    begin
                        state_reg <= ST_STROBE;
                        strobeCount_reg <=
                            auxBusControl_reg[`FLD_STRETCH] ?
                            `STROBE_LONG : `STROBE_SHORT;     // [R7]
                    end
                ST_STROBE:
                begin
                    strobeCount_reg <= strobeCount_reg - 5'h01;
                    if (strobeCount_reg == 5'h01)
                        state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    assign rwStrobeActive = (state_reg == ST_STROBE) && !emulation_reg;

    ////////////////////////////////////////////////////////////////////
    // Latch strobe and pin controls

    latch_strobe_gen u_latch
    (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .suppress    (auxBusControl_reg[`FLD_SUPPRESS]),
        .doubleSpeed (doubleSpeed),
        .extAccess   (extAccess),
        .strobeOut   (strobeOut),
        .strobeDrive (strobeDrive)
    );

    assign latchStrobeOut    = strobeOut && !emulation_reg;
    assign latchStrobeOe     = strobeDrive && !emulation_reg;   // [R2] [R6]
    assign latchStrobePullup = !latchStrobeOe;                  // [R6] [R2]
    assign progStorePullup   = emulation_reg;                   // [R2]
    assign port0Float        = emulation_reg;                   // [R2]
    assign portI2Float       = emulation_reg;                   // [R2]
    assign oscActive         = 1'b1;                            // [R2]
    assign emulationMode     = emulation_reg;
    assign extDataSelect     = auxBusControl_reg[`FLD_EXT_SELECT]; // [R9]
    assign portWeakPullup    = emulation_reg ||
                               !auxBusControl_reg[`FLD_PULLUP_DISABLE]; // [R10]

    always @(posedge clock)
    begin
        if (sys_rst)
            xramSize <= 11'h400;
        else
            xramSize <= size_decode({auxBusControl_reg[`FLD_XRAM_HI],
                                     auxBusControl_reg[`FLD_XRAM_LO]}); // [R8]
    end

endmodule // aux_bus_control

// >>> core/latch_strobe_gen.v
// Address-latch strobe generator with continuous and access-only modes
`include "aux_bus_map.vh"

module latch_strobe_gen
(
    // Clock and reset
    input  wire       clock,
    input  wire       sys_rst,
    // Control
    input  wire       suppress,
    input  wire       doubleSpeed,
    input  wire       extAccess,
    // Strobe out
    output reg        strobeOut,
    output reg        strobeDrive
);

    reg  [3:0] divCount_reg;
    wire [3:0] divLimit;

    assign divLimit = doubleSpeed ? `LATCH_DIV_DOUBLE : `LATCH_DIV_NORMAL;

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            divCount_reg <= 4'h0;
            strobeOut    <= 1'b0;
            strobeDrive  <= 1'b0;
        end
        else
        begin
            if (divCount_reg >= divLimit - 4'h1)
                divCount_reg <= 4'h0;
            else
                divCount_reg <= divCount_reg + 4'h1;
            // Pulse strobeOut once per divider period
            strobeOut   <= (divCount_reg == 4'h0) &&
                           (!suppress || extAccess); // [R4] [R5] [R13]
            // Undriven, weakly high, while suppressed and idle
            strobeDrive <= !suppress || extAccess;   // [R6]
        end
    end

endmodule // latch_strobe_gen

// >>> sim/aux_bus_control_bench.sv
// Self-checking bench for the aux bus control block
`include "aux_bus_map.vh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    failures++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module aux_bus_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] wd, rv; logic [10:0] sz;
        logic ex, pu;} row_t;
    logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, slv;
    logic doubleSpeed = 0, extAccess = 0, wantEmu = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    wire [31:0] prdata;
    wire [10:0] xsz;
    wire pready, pslverr, latchPin, progPin, lOut, lOe, lPu, rwAct, ext;
    wire pwp, emu;
    int failures = 0, check_count = 0, n;
    row_t rows [5] = '{'{8'h00, 8'h00, 11'h100, 1'b0, 1'b1},
        '{8'h05, 8'h05, 11'h200, 1'b0, 1'b1},
        '{8'h0a, 8'h0a, 11'h300, 1'b1, 1'b1},
        '{8'hff, 8'haf, 11'h400, 1'b1, 1'b0},
        '{8'h8c, 8'h8c, 11'h400, 1'b0, 1'b0}};
    always #12.5 clock = ~clock;
    aux_bus_control dut_u (.clock, .sys_rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .doubleSpeed,
        .extAccess, .latchStrobeIn(latchPin), .progStoreStrobeIn(progPin),
        .latchStrobeOut(lOut), .latchStrobeOe(lOe), .latchStrobePullup(lPu),
        .progStorePullup(), .rwStrobeActive(rwAct), .extDataSelect(ext),
        .xramSize(xsz), .portWeakPullup(pwp), .port0Float(), .portI2Float(),
        .oscActive(), .emulationMode(emu));
    strobe_partner part_u (.wantEmu, .latchOut(lOut), .latchOe(lOe),
        .latchPin, .progPin);
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        slv = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task pulses(input logic [7:0] c);
        apb(1, `AUX_BUS_CONTROL_ADDR, c);
        @(posedge clock);
        n = 0;
        repeat (60) @(negedge clock) n += (lOut === 1'b1);
    endtask
    task rwlen(input logic [7:0] c);
        apb(1, `AUX_BUS_CONTROL_ADDR, c);
        apb(1, `AUX_STROBE_CMD_ADDR, 8'h00);
        n = 0;
        repeat (40) @(negedge clock) n += (rwAct === 1'b1);
    endtask
    task give_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #100000;
        failures++;
        give_verdict;
    end
    initial
    begin
        repeat (10) @(posedge clock);
        sys_rst <= 0;
        apb(0, `AUX_BUS_CONTROL_ADDR, 8'h00);
        `CHK("ctrl reset", 32'h0c, rd)
        `CHK("size reset", 11'h400, xsz)
        foreach (rows[i])
        begin
            apb(1, `AUX_BUS_CONTROL_ADDR, rows[i].wd);
            apb(0, `AUX_BUS_CONTROL_ADDR, 8'h00);
            `CHK("ctrl", {24'h0, rows[i].rv}, rd)
            `CHK("size", rows[i].sz, xsz)
            `CHK("ext", rows[i].ex, ext)
            `CHK("pullup", rows[i].pu, pwp)
        end
        apb(0, 12'h0f0, 8'h00);
        `CHK("unmapped", 33'h100000000, {slv, rd})
        rwlen(8'h00);
        `CHK("rw short", 6, n)
        rwlen(8'h20);
        `CHK("rw long", 30, n)
        pulses(8'h0c);
        `CHK("rate x1", 10, n)
        doubleSpeed <= 1;
        pulses(8'h0c);
        `CHK("rate x2", 20, n)
        pulses(8'h0d);
        `CHK("suppressed", 0, n)
        `CHK("pulled", 2'b01, {lOe, lPu})
        extAccess <= 1;
        pulses(8'h0d);
        `CHK("ext access", 1'b1, n > 0)
        wantEmu <= 1;
        sys_rst <= 1;
        repeat (3) @(posedge clock);
        sys_rst <= 0;
        repeat (3) @(posedge clock);
        wantEmu <= 0;
        apb(0, `AUX_STATUS_ADDR, 8'h00);
        `CHK("emu", 3'b111, {rd[0], emu, pwp})
        sys_rst <= 1;
        repeat (3) @(posedge clock);
        sys_rst <= 0;
        repeat (2) @(negedge clock);
        `CHK("emu exit", 1'b0, emu)
        give_verdict;
    end
endmodule // aux_bus_control_bench

// >>> sim/aux_bus_sva.sv
// Assertion checker for the aux bus control block
`include "aux_bus_map.vh"
module aux_bus_sva
(
    // Watched ports
    input wire logic        clock, sys_rst, psel, penable, pslverr,
    input wire logic        latchStrobeIn, progStoreStrobeIn, latchStrobeOut,
    input wire logic        latchStrobeOe, latchStrobePullup, progStorePullup,
    input wire logic        rwStrobeActive, portWeakPullup, port0Float,
    input wire logic        portI2Float, oscActive, emulationMode,
    input wire logic [11:0] paddr,
    input wire logic [10:0] xramSize
);
    logic [5:0] hiCount;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Length of the current read/write strobe
    always_ff @(posedge clock)
        if (sys_rst) hiCount <= 6'h00;
        else hiCount <= rwStrobeActive ? hiCount + 6'h01 : 6'h00;
    property p_emu_entry;
        $fell(sys_rst) |=> emulationMode == $past(!latchStrobeIn && progStoreStrobeIn);
    endproperty
    a_emu_entry: assert property (p_emu_entry)
        else $error("emulation entry wrong");
    property p_emu_pins;
        emulationMode |-> progStorePullup && port0Float && portI2Float
            && oscActive && portWeakPullup && latchStrobePullup;
    endproperty
    a_emu_pins: assert property (p_emu_pins)
        else $error("emulation pin state wrong");
    property p_emu_hold;
        emulationMode |=> emulationMode;
    endproperty
    a_emu_hold: assert property (p_emu_hold)
        else $error("emulation left without reset");
    property p_rate;
        latchStrobeOut |=> !latchStrobeOut [*2];
    endproperty
    a_rate: assert property (p_rate)
        else $error("latch strobe too fast");
    property p_pull;
        latchStrobePullup == !latchStrobeOe;
    endproperty
    a_pull: assert property (p_pull)
        else $error("latch pin neither driven nor pulled");
    property p_rw_len;
        $fell(rwStrobeActive) |-> hiCount == 6'h06 || hiCount == 6'h1e;
    endproperty
    a_rw_len: assert property (p_rw_len)
        else $error("read/write strobe length wrong");
    property p_size;
        xramSize inside {11'h100, 11'h200, 11'h300, 11'h400};
    endproperty
    a_size: assert property (p_size)
        else $error("ram size not legal");
    property p_slverr;
        psel && penable |-> pslverr == !(paddr inside {`AUX_BUS_CONTROL_ADDR,
            `AUX_STATUS_ADDR, `AUX_STROBE_CMD_ADDR});
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("error response wrong");
endmodule // aux_bus_sva
bind aux_bus_control aux_bus_sva chk_u (.clock, .sys_rst, .psel, .penable,
    .pslverr, .latchStrobeIn, .progStoreStrobeIn, .latchStrobeOut,
    .latchStrobeOe, .latchStrobePullup, .progStorePullup, .rwStrobeActive,
    .portWeakPullup, .port0Float, .portI2Float, .oscActive, .emulationMode,
    .paddr, .xramSize);

// >>> sim/strobe_partner.sv
// Emulator-side model of the strobe pins
module strobe_partner
(
    // Bench control
    input  wire logic wantEmu,
    // Device side of the latch pin
    input  wire logic latchOut,
    input  wire logic latchOe,
    // Pin levels
    output logic      latchPin,
    output logic      progPin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Emulator holds latch pin low, else pin pulled up when undriven
    assign latchPin = wantEmu ? 1'b0 : latchOe ? latchOut : 1'b1;
    assign progPin = 1'b1;
endmodule // strobe_partner
